/* fcch_top.sv */
// Command handler of a quad-capable serial flash: frames opcodes from the link.
// Assumes link pins are asynchronous to sys_clk_i; core ops report busy/done.
`timescale 1ns/100ps
`default_nettype none
module fcch_top #(
  parameter int RST_LAT_CYCLES = fcch_pkg::RST_LAT_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       clk_en_i,
  input  wire logic       cs_n_i,
  input  wire logic       sclk_i,
  input  wire logic [3:0] dq_i,
  output logic      [3:0] dq_o,
  output logic      [3:0] dq_oe_n_o,
  input  wire logic       deep_power_down_i,
  input  wire logic       quad_read_enhancement_mode_i,
  input  wire logic       op_busy_i,
  input  wire logic       op_done_i,
  input  wire logic       op_is_erase_i,
  input  wire logic [5:0] nv_prot_bits_i,
  output logic      [7:0] status_o,
  output logic            four_bit_command_mode_o,
  output logic            enh_release_o,
  output logic            op_abort_o,
  output logic            op_start_o,
  output logic      [7:0] op_code_o,
  output logic            write_rejected_o,
  output logic            illegal_quad_op_o,
  output logic            status_regs_reset_o
);
  // Two-stage synchronisers for the link pins
  logic [1:0] cs_sync_ff;
  logic [1:0] sclk_sync_ff;
  logic [3:0] dq_s1_ff;
  logic [3:0] dq_s2_ff;
  logic       sclk_prev_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cs_sync_ff   <= 2'h3;
      sclk_sync_ff <= 2'h0;
      dq_s1_ff     <= 4'h0;
      dq_s2_ff     <= 4'h0;
      sclk_prev_ff <= 1'b0;
    end else if (clk_en_i) begin
      cs_sync_ff   <= {cs_sync_ff[0], cs_n_i};
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_i};
      dq_s1_ff     <= dq_i;
      dq_s2_ff     <= dq_s1_ff;
      sclk_prev_ff <= sclk_sync_ff[1];
    end
  end

  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;
  assign cs_low    = ~cs_sync_ff[1];
  assign sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_prev_ff;

  // Frame end pulse on chip select rising
  logic cs_low_prev_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cs_low_prev_ff <= 1'b0;
    end else if (clk_en_i) begin
      cs_low_prev_ff <= cs_low;
    end
  end
  logic frame_end;
  assign frame_end = cs_low_prev_ff & ~cs_low;

  // Opcode shifter, MSB first, one or four bits per rising edge
  logic       quad_mode_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic       op_valid_ff;
  logic [7:0] opcode_ff;
  logic       op_full;
  assign op_full = (bit_cnt_ff >= 4'd8);
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      shift_ff    <= 8'h00;
      bit_cnt_ff  <= 4'h0;
      op_valid_ff <= 1'b0;
      opcode_ff   <= 8'h00;
    end else if (clk_en_i) begin
      op_valid_ff <= 1'b0;
      if (!cs_low) begin
        bit_cnt_ff <= 4'h0;
      end else if (sclk_rise && !op_full) begin
        if (quad_mode_ff || quad_read_enhancement_mode_i) begin
          shift_ff   <= {shift_ff[3:0], dq_s2_ff};
          bit_cnt_ff <= bit_cnt_ff + 4'd4;
          if (bit_cnt_ff == 4'd4) begin
            opcode_ff   <= {shift_ff[3:0], dq_s2_ff};
            op_valid_ff <= 1'b1;
          end
        end else begin
          shift_ff   <= {shift_ff[6:0], dq_s2_ff[0]};
          bit_cnt_ff <= bit_cnt_ff + 4'd1;
          if (bit_cnt_ff == 4'd7) begin
            opcode_ff   <= {shift_ff[6:0], dq_s2_ff[0]};
            op_valid_ff <= 1'b1;
          end
        end
      end
    end
  end

  // Frame bookkeeping: which opcode this frame carried
  logic       frame_has_op_ff;
  logic [7:0] frame_op_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      frame_has_op_ff <= 1'b0;
      frame_op_ff     <= 8'h00;
    end else if (clk_en_i) begin
      if (frame_end) begin
        frame_has_op_ff <= 1'b0;
      end else if (op_valid_ff) begin
        frame_has_op_ff <= 1'b1;
        frame_op_ff     <= opcode_ff;
      end
    end
  end

  // Commands act when chip select rises after a whole opcode
  fcch_pkg::fcch_cmd_t cmd;
  logic act;
  assign act = frame_end && frame_has_op_ff && !deep_power_down_i;
  always_comb begin
    cmd            = '0;
    cmd.reset_arm  = act && frame_op_ff == fcch_pkg::OP_RESET_ARM;
    cmd.reset_exec = act && frame_op_ff == fcch_pkg::OP_RESET_EXEC;
    cmd.quad_entry = act && frame_op_ff == fcch_pkg::OP_QUAD_ENTRY;
    cmd.quad_exit  = act && frame_op_ff == fcch_pkg::OP_QUAD_EXIT;
    cmd.wr_enable  = act && frame_op_ff == fcch_pkg::OP_WR_ENABLE;
    cmd.wr_disable = act && frame_op_ff == fcch_pkg::OP_WR_DISABLE;
    cmd.vol_wr_en  = act && frame_op_ff == fcch_pkg::OP_VOL_WR_EN;
    case (frame_op_ff)
      fcch_pkg::OP_PP3, fcch_pkg::OP_PP4, fcch_pkg::OP_QPP3, fcch_pkg::OP_QPP4,
      fcch_pkg::OP_SE3, fcch_pkg::OP_SE4, fcch_pkg::OP_HBE3, fcch_pkg::OP_HBE4,
      fcch_pkg::OP_BE3, fcch_pkg::OP_BE4, fcch_pkg::OP_CE1, fcch_pkg::OP_CE2,
      fcch_pkg::OP_STAT_WRITE: cmd.write_op = act;
      default:                 cmd.write_op = 1'b0;
    endcase
  end

  // Opcodes refused while in four-bit command mode
  logic quad_illegal;
  always_comb begin
    case (frame_op_ff)
      fcch_pkg::OP_READ3, fcch_pkg::OP_READ4, fcch_pkg::OP_DUAL_OUT3,
      fcch_pkg::OP_DUAL_OUT4, fcch_pkg::OP_DUAL_IO3, fcch_pkg::OP_DUAL_IO4,
      fcch_pkg::OP_QUAD_OUT3, fcch_pkg::OP_QUAD_OUT4, fcch_pkg::OP_QPP3,
      fcch_pkg::OP_QPP4: quad_illegal = quad_mode_ff;
      default:           quad_illegal = 1'b0;
    endcase
  end

  // Reset arming and execution
  logic reset_armed_ff;
  logic soft_reset;
  assign soft_reset = cmd.reset_exec && reset_armed_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reset_armed_ff <= 1'b0;
    end else if (clk_en_i && act) begin
      reset_armed_ff <= cmd.reset_arm;
    end
  end

  // Post-reset recovery counter; busy stays high while it runs
  logic [31:0] rec_cnt_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rec_cnt_ff <= 32'h0;
    end else if (clk_en_i) begin
      if (soft_reset && op_busy_i && op_is_erase_i) begin
        rec_cnt_ff <= 32'(RST_LAT_CYCLES);
      end else if (rec_cnt_ff != 32'h0) begin
        rec_cnt_ff <= rec_cnt_ff - 32'h1;
      end
    end
  end

  // Interface width
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      quad_mode_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (soft_reset) begin
        quad_mode_ff <= 1'b0;
      end else if (cmd.quad_entry) begin
        quad_mode_ff <= 1'b1;
      end else if (cmd.quad_exit && !quad_read_enhancement_mode_i) begin
        quad_mode_ff <= 1'b0;
      end
    end
  end

  // Write enable latch and volatile write arming
  logic wel_ff;
  logic vol_armed_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wel_ff       <= 1'b0;
      vol_armed_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (soft_reset) begin
        wel_ff <= 1'b0;
      end else if (cmd.wr_enable) begin
        wel_ff <= 1'b1;
      end else if (cmd.wr_disable || op_done_i) begin
        wel_ff <= 1'b0;
      end
      if (act) begin
        vol_armed_ff <= cmd.vol_wr_en && !soft_reset;
      end
    end
  end

  // Status write data capture: byte after opcode, MSB first
  logic [7:0] data_sh_ff;
  logic [3:0] data_cnt_ff;
  logic       data_byte_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      data_sh_ff   <= 8'h00;
      data_cnt_ff  <= 4'h0;
      data_byte_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (!cs_low) begin
        data_cnt_ff  <= 4'h0;
        data_byte_ff <= 1'b0;
      end else if (sclk_rise && op_full && data_cnt_ff < 4'd8) begin
        if (quad_mode_ff) begin
          data_sh_ff  <= {data_sh_ff[3:0], dq_s2_ff};
          data_cnt_ff <= data_cnt_ff + 4'd4;
        end else begin
          data_sh_ff  <= {data_sh_ff[6:0], dq_s2_ff[0]};
          data_cnt_ff <= data_cnt_ff + 4'd1;
        end
        data_byte_ff <= (data_cnt_ff == 4'd7) || (quad_mode_ff && data_cnt_ff == 4'd4);
      end
    end
  end

  // Volatile copy of status bits seven to two, updated at frame end
  logic [5:0] vol_prot_ff;
  logic       vol_write;
  assign vol_write = act && frame_op_ff == fcch_pkg::OP_STAT_WRITE && vol_armed_ff
                     && data_byte_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      vol_prot_ff <= 6'h00;
    end else if (clk_en_i) begin
      if (soft_reset) begin
        vol_prot_ff <= nv_prot_bits_i;
      end else if (vol_write) begin
        vol_prot_ff <= data_sh_ff[7:2];
      end
    end
  end

  // Status byte assembly
  logic [7:0] status_now;
  assign status_now = {vol_prot_ff, wel_ff, op_busy_i | (rec_cnt_ff != 32'h0)};

  // Status read output, repeats while chip select low, shifted on falling edge
  logic [7:0] rd_sh_ff;
  logic [2:0] rd_cnt_ff;
  logic       rd_act_ff;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rd_sh_ff  <= 8'h00;
      rd_cnt_ff <= 3'h0;
      rd_act_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (!cs_low) begin
        rd_act_ff <= 1'b0;
      end else if (op_valid_ff && opcode_ff == fcch_pkg::OP_STAT_READ) begin
        rd_act_ff <= 1'b1;
        rd_sh_ff  <= status_now;
        rd_cnt_ff <= quad_mode_ff ? 3'd4 : 3'd1;
      end else if (rd_act_ff && sclk_fall && rd_cnt_ff != 3'h0) begin
        rd_sh_ff <= quad_mode_ff ? {rd_sh_ff[3:0], 4'h0} : {rd_sh_ff[6:0], 1'b0};
        rd_cnt_ff <= quad_mode_ff ? 3'(rd_cnt_ff + 3'd4) : 3'(rd_cnt_ff + 3'd1);
      end else if (rd_act_ff && sclk_fall) begin
        rd_sh_ff  <= status_now;
        rd_cnt_ff <= quad_mode_ff ? 3'd4 : 3'd1;
      end
    end
  end

  // Output registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dq_o                    <= 4'h0;
      dq_oe_n_o               <= 4'hf;
      status_o                <= fcch_pkg::SR_RESET_VAL;
      four_bit_command_mode_o <= 1'b0;
      enh_release_o           <= 1'b0;
      op_abort_o              <= 1'b0;
      op_start_o              <= 1'b0;
      op_code_o               <= 8'h00;
      write_rejected_o        <= 1'b0;
      illegal_quad_op_o       <= 1'b0;
      status_regs_reset_o     <= 1'b0;
    end else if (clk_en_i) begin
      dq_o      <= quad_mode_ff ? rd_sh_ff[7:4] : {2'b00, rd_sh_ff[7], 1'b0};
      dq_oe_n_o <= !rd_act_ff ? 4'hf : (quad_mode_ff ? 4'h0 : 4'hd);
      status_o                <= status_now;
      four_bit_command_mode_o <= quad_mode_ff;
      enh_release_o <= cmd.quad_exit && quad_read_enhancement_mode_i;
      op_abort_o    <= soft_reset && op_busy_i;
      op_start_o    <= cmd.write_op && wel_ff && !vol_write && !quad_illegal
                       && !op_busy_i;
      op_code_o     <= frame_op_ff;
      write_rejected_o    <= cmd.write_op && !wel_ff && !vol_write;
      illegal_quad_op_o   <= act && quad_illegal;
      status_regs_reset_o <= soft_reset;
    end
  end
endmodule
`default_nettype wire

/* fcch_pkg.sv */
// Package for the flash command handler: opcodes, status layout, timing.
// Assumes a 200 MHz system clock sampling the serial link pins.
`default_nettype none
package fcch_pkg;
  localparam logic [7:0] OP_RESET_ARM   = 8'h66;
  localparam logic [7:0] OP_RESET_EXEC  = 8'h99;
  localparam logic [7:0] OP_QUAD_ENTRY  = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT   = 8'hff;
  localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
  localparam logic [7:0] OP_VOL_WR_EN   = 8'h50;
  localparam logic [7:0] OP_STAT_WRITE  = 8'h01;
  localparam logic [7:0] OP_STAT_READ   = 8'h05;
  localparam logic [7:0] OP_READ3       = 8'h03;
  localparam logic [7:0] OP_READ4       = 8'h13;
  localparam logic [7:0] OP_DUAL_OUT3   = 8'h3b;
  localparam logic [7:0] OP_DUAL_OUT4   = 8'h3c;
  localparam logic [7:0] OP_DUAL_IO3    = 8'hbb;
  localparam logic [7:0] OP_DUAL_IO4    = 8'hbc;
  localparam logic [7:0] OP_QUAD_OUT3   = 8'h6b;
  localparam logic [7:0] OP_QUAD_OUT4   = 8'h6c;
  localparam logic [7:0] OP_QPP3        = 8'h32;
  localparam logic [7:0] OP_QPP4        = 8'h34;
  localparam logic [7:0] OP_PP3         = 8'h02;
  localparam logic [7:0] OP_PP4         = 8'h12;
  localparam logic [7:0] OP_SE3         = 8'h20;
  localparam logic [7:0] OP_SE4         = 8'h21;
  localparam logic [7:0] OP_HBE3        = 8'h52;
  localparam logic [7:0] OP_HBE4        = 8'h5c;
  localparam logic [7:0] OP_BE3         = 8'hd8;
  localparam logic [7:0] OP_BE4         = 8'hdc;
  localparam logic [7:0] OP_CE1         = 8'hc7;
  localparam logic [7:0] OP_CE2         = 8'h60;
  // Status byte fields
  localparam int         SR_BUSY_BIT    = 0;
  localparam int         SR_WEL_BIT     = 1;
  localparam int         SR_PROT_LSB    = 2;
  localparam int         SR_PROT_W      = 6;
  localparam logic [7:0] SR_RESET_VAL   = 8'h00;
  localparam logic [7:0] SR2_RESET_VAL  = 8'h02;
  localparam logic [7:0] SR3_RESET_VAL  = 8'h00;
  // Timing
  localparam int         CLK_PERIOD_PS  = 5000;
  localparam int         RST_LAT_NS     = 28000;
  localparam int         RST_LAT_CYC    = (RST_LAT_NS * 1000) / CLK_PERIOD_PS;
  localparam int         VOL_UPD_NS     = 50;
  localparam int         VOL_UPD_CYC    = (VOL_UPD_NS * 1000) / CLK_PERIOD_PS;
  // Decoded command pulse set handed between stages
  typedef struct packed {
    logic reset_arm;
    logic reset_exec;
    logic quad_entry;
    logic quad_exit;
    logic wr_enable;
    logic wr_disable;
    logic vol_wr_en;
    logic write_op;
  } fcch_cmd_t;
endpackage
`default_nettype wire

/* fcch_monitor.sv */
// Concurrent checks on the command handler's ports.
// Assumes clk_en_i is held high and the link pins change off sys_clk_i edges.
`timescale 1ns/100ps
`default_nettype none
module fcch_monitor #(
  parameter int RST_LAT_CYCLES = fcch_pkg::RST_LAT_CYC
) (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       clk_en_i,
  input wire logic       cs_n_i,
  input wire logic       sclk_i,
  input wire logic [3:0] dq_i,
  input wire logic [3:0] dq_o,
  input wire logic [3:0] dq_oe_n_o,
  input wire logic       deep_power_down_i,
  input wire logic       quad_read_enhancement_mode_i,
  input wire logic       op_busy_i,
  input wire logic       op_done_i,
  input wire logic       op_is_erase_i,
  input wire logic [5:0] nv_prot_bits_i,
  input wire logic [7:0] status_o,
  input wire logic       four_bit_command_mode_o,
  input wire logic       enh_release_o,
  input wire logic       op_abort_o,
  input wire logic       op_start_o,
  input wire logic [7:0] op_code_o,
  input wire logic       write_rejected_o,
  input wire logic       illegal_quad_op_o,
  input wire logic       status_regs_reset_o
);
  // One clock domain, one reset
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Pins released once the frame is over
  a_idle_release: assert property (
    cs_n_i [*8] |-> dq_oe_n_o == 4'hf) else $error("pins driven while deselected");
  // Busy bit follows a running write cycle
  a_busy_shown: assert property (
    op_busy_i [*2] |-> status_o[0]) else $error("busy bit low during write cycle");
  // Latch drops when a write finishes
  a_latch_done: assert property (
    op_done_i |-> ##[1:3] !status_o[1]) else $error("latch kept after write done");
  // Write op accepted or refused by the latch
  a_start_latch: assert property (
    op_start_o |-> $past(status_o[1])) else $error("write started without latch");
  a_reject_latch: assert property (
    write_rejected_o |-> !$past(status_o[1])) else $error("write refused with latch set");
  // Soft reset restores stored bits and single-bit mode
  a_reset_restore: assert property (
    status_regs_reset_o |-> ##[1:2] status_o[7:1] == {nv_prot_bits_i, 1'b0})
    else $error("status not restored by soft reset");
  a_reset_single: assert property (
    status_regs_reset_o |-> ##[0:1] !four_bit_command_mode_o) else $error("quad kept");
  a_abort_reset: assert property (
    op_abort_o |-> status_regs_reset_o) else $error("abort without soft reset");
  // No soft reset acts at frame end in deep power-down
  a_sleep_hold: assert property (
    deep_power_down_i [*8] |-> !status_regs_reset_o) else $error("reset in power-down");
  // Enhancement release leaves the mode alone; refusals only in four-bit mode
  a_enh_keep: assert property (
    enh_release_o |=> $stable(four_bit_command_mode_o)) else $error("mode left on release");
  a_refuse_quad: assert property (
    illegal_quad_op_o |-> four_bit_command_mode_o) else $error("refusal outside quad");
endmodule
bind fcch_top fcch_monitor #(.RST_LAT_CYCLES(RST_LAT_CYCLES)) u_mon (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .cs_n_i(cs_n_i),
  .sclk_i(sclk_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
  .deep_power_down_i(deep_power_down_i),
  .quad_read_enhancement_mode_i(quad_read_enhancement_mode_i),
  .op_busy_i(op_busy_i), .op_done_i(op_done_i), .op_is_erase_i(op_is_erase_i),
  .nv_prot_bits_i(nv_prot_bits_i), .status_o(status_o),
  .four_bit_command_mode_o(four_bit_command_mode_o), .enh_release_o(enh_release_o),
  .op_abort_o(op_abort_o), .op_start_o(op_start_o), .op_code_o(op_code_o),
  .write_rejected_o(write_rejected_o), .illegal_quad_op_o(illegal_quad_op_o),
  .status_regs_reset_o(status_regs_reset_o));
`default_nettype wire

/* fcch_host_model.sv */
// Behavioural host controller driving chip select, serial clock and data.
// Assumes the bench resolves the shared data wires from the device's enables.
`timescale 1ns/100ps
`default_nettype none
module fcch_host_model (
  output logic            cs_n_o,
  output logic            sclk_o,
  output logic      [3:0] dq_o,
  input  wire logic [3:0] dq_i
);
  // Deselected, clock parked low outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    dq_o = 4'h0;
  end
  // One frame: nb command bits, then nrd read clocks sampled in the high phase
  task automatic xfer(input logic [15:0] d, input int nb, input bit q, input int nrd,
                      output logic [15:0] rd);
    int w;
    w = q ? 4 : 1;
    rd = 16'h0;
    cs_n_o = 1'b0;
    for (int i = 0; i < nb + nrd * w; i += w) begin
      if (i < nb) dq_o = q ? d[15 - i -: 4] : {3'h0, d[15 - i]};
      #32 sclk_o = 1'b1;
      #28 rd = {rd[14:0], dq_i[1]};
      #4 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    dq_o = ~dq_o; // Released lines lose the last value
    #100;
  endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the flash command handler.
// Assumes the host model drives the link; side inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        sys_clk_i, reset_i, dpd, enh, busy, done, erase;
  logic        cs_n, sclk, quad, enh_rel, abrt, start, rej, ill, srst;
  logic [5:0]  nv;
  logic [3:0]  h_dq, d_dq, d_oe_n, bus;
  logic [7:0]  st, opc;
  logic [15:0] rd;
  logic [7:0]  tbl [10] = '{8'h03, 8'h13, 8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'h6b, 8'h6c,
                           8'h32, 8'h34};
  int          err_total, tests_run, cyc, n_rej, n_st, n_ill, n_rst, n_ab, n_enh;
  // Shared data wires: device wins where it enables its driver
  assign bus = (~d_oe_n & d_dq) | (d_oe_n & h_dq);
  fcch_top #(.RST_LAT_CYCLES(40)) u_dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .cs_n_i(cs_n),
    .sclk_i(sclk), .dq_i(bus), .dq_o(d_dq), .dq_oe_n_o(d_oe_n),
    .deep_power_down_i(dpd), .quad_read_enhancement_mode_i(enh), .op_busy_i(busy),
    .op_done_i(done), .op_is_erase_i(erase), .nv_prot_bits_i(nv), .status_o(st),
    .four_bit_command_mode_o(quad), .enh_release_o(enh_rel), .op_abort_o(abrt),
    .op_start_o(start), .op_code_o(opc), .write_rejected_o(rej),
    .illegal_quad_op_o(ill), .status_regs_reset_o(srst));
  fcch_host_model u_host (.cs_n_o(cs_n), .sclk_o(sclk), .dq_o(h_dq), .dq_i(bus));
  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Pulse counters and hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (rej === 1'b1) n_rej++;
    if (start === 1'b1) n_st++;
    if (ill === 1'b1) n_ill++;
    if (srst === 1'b1) n_rst++;
    if (abrt === 1'b1) n_ab++;
    if (enh_rel === 1'b1) n_enh++;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic f(input logic [7:0] op, input bit q);
    u_host.xfer({op, 8'h00}, 8, q, 0, rd);
  endtask
  // Status read over two repeats of the byte
  task automatic rs(input logic [7:0] exp);
    u_host.xfer(16'h0500, 8, 1'b0, 15, rd);
    chk8(rd[15:8], exp);
    chk8(rd[7:0], exp);
  endtask
  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {reset_i, dpd, enh, busy, done, erase, nv} = {1'b1, 11'h0};
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i) reset_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    rs(8'h00);
    f(8'h06, 0);
    rs(8'h02);
    f(8'h04, 0);
    rs(8'h00);
    f(8'h02, 0);
    chkn(n_rej, 1);
    f(8'h06, 0);
    f(8'h02, 0);
    chkn(n_st, 1);
    chk8(opc, 8'h02);
    @(negedge sys_clk_i) busy = 1'b1;
    rs(8'h03);
    @(negedge sys_clk_i) {busy, done} = 2'b01;
    @(negedge sys_clk_i) done = 1'b0;
    rs(8'h00);
    // Reset in mid-erase; busy stays set after the erase ends until the recovery count started by the reset runs out
    f(8'h06, 0);
    @(negedge sys_clk_i) {busy, erase} = 2'b11;
    f(8'h66, 0);
    f(8'h99, 0);
    @(negedge sys_clk_i) {busy, erase} = 2'b00;
    @(negedge sys_clk_i);
    chkn(n_ab, 1);
    chkn(n_rst, 1);
    chk8(st, 8'h01);
    repeat (60) @(negedge sys_clk_i);
    chk8(st, 8'h00);
    f(8'h66, 0);
    f(8'h06, 0);
    f(8'h99, 0);
    chkn(n_rst, 1);
    rs(8'h02);
    @(negedge sys_clk_i) nv = 6'h2a;
    f(8'h50, 0);
    u_host.xfer(16'h01fc, 16, 1'b0, 0, rd);
    repeat (2) @(negedge sys_clk_i);
    chk8(st, 8'hfe);
    chkn(n_st, 1);
    f(8'h66, 0);
    f(8'h99, 0);
    chk8(st, 8'ha8);
    u_host.xfer(16'h0600, 4, 1'b0, 0, rd);
    rs(8'ha8);
    f(8'h38, 0);
    chk8({7'h0, quad}, 8'h01);
    f(8'h06, 1);
    chk8(st, 8'haa);
    foreach (tbl[k]) f(tbl[k], 1);
    chkn(n_ill, 10);
    @(negedge sys_clk_i) enh = 1'b1;
    f(8'hff, 1);
    chkn(n_enh, 1);
    chk8({7'h0, quad}, 8'h01);
    @(negedge sys_clk_i) enh = 1'b0;
    f(8'hff, 1);
    chk8({7'h0, quad}, 8'h00);
    f(8'hff, 0);
    chkn(n_enh, 1);
    chk8({7'h0, quad}, 8'h00);
    f(8'h38, 0);
    @(negedge sys_clk_i) enh = 1'b1;
    f(8'h66, 1);
    f(8'h99, 1);
    @(negedge sys_clk_i) enh = 1'b0;
    chk8({7'h0, quad}, 8'h00);
    chkn(n_rst, 3);
    f(8'h06, 0);
    f(8'h66, 1);
    f(8'h99, 1);
    f(8'h66, 0);
    f(8'h99, 0);
    chkn(n_rst, 4);
    chk8(st, 8'ha8);
    @(negedge sys_clk_i) dpd = 1'b1;
    f(8'h66, 0);
    f(8'h99, 0);
    @(negedge sys_clk_i) dpd = 1'b0;
    chkn(n_rst, 4);
    chk8(st, 8'ha8);
    end_sim();
  end
endmodule
`default_nettype wire
